// ==== common/adcs_defines.svh ====
`ifndef ADCS_DEFINES_SVH
`define ADCS_DEFINES_SVH

// Register byte offsets.
`define ADCS_OFF_CTRL 8'h00
`define ADCS_OFF_SEL 8'h04
`define ADCS_OFF_RES_LO 8'h08
`define ADCS_OFF_RES_HI 8'h0c
`define ADCS_OFF_STATUS 8'h10

// Control word fields.
`define ADCS_CTRL_EN 0
`define ADCS_CTRL_START 1
`define ADCS_CTRL_AUTO 2
`define ADCS_CTRL_DONE 3
`define ADCS_CTRL_IE 4
`define ADCS_CTRL_DIV_LO 5
`define ADCS_CTRL_FREE 8

// Selection word field, also used by the status word, then status-only fields.
`define ADCS_SEL_REF 6
`define ADCS_STAT_BUSY 8
`define ADCS_STAT_FIRST 9

// Timing in half converter clock cycles from the start of a conversion.
`define ADCS_SAMP_NORM 6'd3
`define ADCS_END_NORM 6'd26
`define ADCS_SAMP_FIRST 6'd27
`define ADCS_END_FIRST 6'd50
`define ADCS_SAMP_AUTO 6'd4
`define ADCS_END_AUTO 6'd27
`define ADCS_SAMP_FREE 6'd5
`define ADCS_END_FREE 6'd28

`define ADCS_FULL_SCALE 10'h3ff
`define ADCS_RESP_OKAY 2'b00
`define ADCS_RESP_SLVERR 2'b10

`endif

// ==== common/adcs_pkg.sv ====
package adcs_pkg;

  typedef enum logic [1:0] {st_idle, st_arm, st_conv} adcs_state_t;

  // Request toward the analog core: start and sample strobes are one-cycle pulses.
  typedef struct packed {
    logic start;
    logic sample;
    logic ref_sel;
    logic [3:0] channel;
  } adcs_core_req_t;

  // Answer from the analog core; over is set when the input exceeds the reference.
  typedef struct packed {
    logic over;
    logic [9:0] code;
  } adcs_core_rsp_t;

endpackage

// ==== src/adcs_sequencer.sv ====
`timescale 1ns/10ps
`include "adcs_defines.svh"
// Function
// - Prescaler runs while enabled, held otherwise.
// - Software start begins at next converter edge.
// - Conversion lasts 13 cycles, first 25.
// - Sample at 1.5 cycles, first at 13.5.
// - Completion stores result, sets flag, clears start.
// - Trigger resets prescaler; sample two cycles later.
// - Triggered conversion 13.5 cycles plus synchroniser.
// - Free running restarts; sample 2.5, total 14.
// - Selection buffered, copied until start, then frozen.
// - Copying resumes in last converter cycle.
// - Free-run reselection affects only later conversions.
// - Sleep entry starts a conversion when idle in single mode with interrupt enabled.
// - Completion request raised even after other wakeup.
// - Over-range input saturates at full scale.
// - Start bit reads one while converting.
// - Trigger edge starts; edges during conversion ignored.
// - Low byte read blocks updates until high read.
module adcs_sequencer (
  input wire logic ref_clk_in, // System clock.
  input wire logic nrst_in, // Synchronous reset, active low.
  input wire logic ce_in, // Clock enable; all state holds while low.
  input wire logic [7:0] s_axi_awaddr_in, // Write address.
  input wire logic s_axi_awvalid_in, // Write address valid.
  output logic s_axi_awready_out, // Write address ready.
  input wire logic [31:0] s_axi_wdata_in, // Write data.
  input wire logic [3:0] s_axi_wstrb_in, // Write byte strobes.
  input wire logic s_axi_wvalid_in, // Write data valid.
  output logic s_axi_wready_out, // Write data ready.
  output logic [1:0] s_axi_bresp_out, // Write response.
  output logic s_axi_bvalid_out, // Write response valid.
  input wire logic s_axi_bready_in, // Write response ready.
  input wire logic [7:0] s_axi_araddr_in, // Read address.
  input wire logic s_axi_arvalid_in, // Read address valid.
  output logic s_axi_arready_out, // Read address ready.
  output logic [31:0] s_axi_rdata_out, // Read data.
  output logic [1:0] s_axi_rresp_out, // Read response.
  output logic s_axi_rvalid_out, // Read data valid.
  input wire logic s_axi_rready_in, // Read data ready.
  input wire logic trig_in, // Auto-trigger source, asynchronous.
  input wire logic sleep_halt_in, // CPU halted in idle or noise-reduction sleep.
  input wire adcs_pkg::adcs_core_rsp_t core_rsp_in, // Result from the analog core.
  output adcs_pkg::adcs_core_req_t core_req_out, // Strobes and selection to the core.
  output logic irq_out // Completion interrupt request.
);

  ////////////////////////////////////////////////////////////////////////////////
  // Prescale code 0 behaves as code 1, so division runs from 2 to 128.
  function automatic logic [6:0] div_mask(input logic [2:0] code, input logic half);
    logic [2:0] k;
    k = (code == 3'h0) ? 3'h1 : code;
    if (half)
      div_mask = 7'((8'h01 << (k - 3'h1)) - 8'h01);
    else
      div_mask = 7'((8'h01 << k) - 8'h01);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  logic en_ff, start_ff, auto_ff, done_ff, ie_ff, free_ff;
  logic nxt_en, nxt_start, nxt_auto, nxt_done, nxt_ie, nxt_free;
  logic [2:0] div_ff, nxt_div;
  logic [3:0] buf_ch_ff, nxt_buf_ch, act_ch_ff, nxt_act_ch;
  logic buf_ref_ff, nxt_buf_ref, act_ref_ff, nxt_act_ref, last_ref_ff, nxt_last_ref;
  logic first_ff, nxt_first;
  adcs_pkg::adcs_state_t state_ff, nxt_state;
  logic [6:0] presc_ff, nxt_presc;
  logic [5:0] hc_ff, nxt_hc, samp_ff, nxt_samp, end_ff, nxt_end;
  logic [9:0] result_ff, nxt_result;
  logic rlock_ff, nxt_rlock, sleep_d_ff;
  logic core_start_ff, nxt_core_start, core_sample_ff, nxt_core_sample;
  logic trig_s1_ff, trig_s2_ff, trig_s3_ff;
  logic aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got;
  logic [7:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic half_tick, full_tick, trig_edge;
  logic [31:0] ctrl_word, sel_word, stat_word, wmask, ctrl_m, sel_m;
  logic [5:0] hc_inc;

  assign s_axi_awready_out = ce_in & ~aw_got_ff & ~bvalid_ff;
  assign s_axi_wready_out = ce_in & ~w_got_ff & ~bvalid_ff;
  assign s_axi_arready_out = ce_in & ~rvalid_ff;
  assign s_axi_bvalid_out = bvalid_ff;
  assign s_axi_bresp_out = bresp_ff;
  assign s_axi_rvalid_out = rvalid_ff;
  assign s_axi_rdata_out = rdata_ff;
  assign s_axi_rresp_out = rresp_ff;
  assign core_req_out = '{start: core_start_ff, sample: core_sample_ff,
                          ref_sel: act_ref_ff, channel: act_ch_ff};
  assign irq_out = done_ff & ie_ff;

  // Half ticks mark both edges of the converter clock so .5 cycle timings fit.
  assign half_tick = (presc_ff & div_mask(div_ff, 1'b1)) == div_mask(div_ff, 1'b1);
  assign full_tick = (presc_ff & div_mask(div_ff, 1'b0)) == div_mask(div_ff, 1'b0);
  // Two sync stages plus the edge stage make three CPU cycles of latency.
  assign trig_edge = trig_s2_ff & ~trig_s3_ff;
  assign hc_inc = hc_ff + 6'd1;

  always_comb
  begin
    ctrl_word = '0;
    ctrl_word[`ADCS_CTRL_EN] = en_ff;
    ctrl_word[`ADCS_CTRL_START] = start_ff | (state_ff != adcs_pkg::st_idle);
    ctrl_word[`ADCS_CTRL_AUTO] = auto_ff;
    ctrl_word[`ADCS_CTRL_DONE] = done_ff;
    ctrl_word[`ADCS_CTRL_IE] = ie_ff;
    ctrl_word[`ADCS_CTRL_DIV_LO +: 3] = div_ff;
    ctrl_word[`ADCS_CTRL_FREE] = free_ff;
    sel_word = '0;
    sel_word[3:0] = buf_ch_ff;
    sel_word[`ADCS_SEL_REF] = buf_ref_ff;
    stat_word = '0;
    stat_word[3:0] = act_ch_ff;
    stat_word[`ADCS_SEL_REF] = act_ref_ff;
    stat_word[`ADCS_STAT_BUSY] = state_ff == adcs_pkg::st_conv;
    stat_word[`ADCS_STAT_FIRST] = first_ff;
    wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
    ctrl_m = (ctrl_word & ~wmask) | (wdata_ff & wmask);
    sel_m = (sel_word & ~wmask) | (wdata_ff & wmask);
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    nxt_en = en_ff;
    nxt_start = start_ff;
    nxt_auto = auto_ff;
    nxt_done = done_ff;
    nxt_ie = ie_ff;
    nxt_div = div_ff;
    nxt_free = free_ff;
    nxt_buf_ch = buf_ch_ff;
    nxt_buf_ref = buf_ref_ff;
    nxt_act_ch = act_ch_ff;
    nxt_act_ref = act_ref_ff;
    nxt_last_ref = last_ref_ff;
    nxt_first = first_ff;
    nxt_state = state_ff;
    nxt_presc = presc_ff + 7'd1;
    nxt_hc = hc_ff;
    nxt_samp = samp_ff;
    nxt_end = end_ff;
    nxt_result = result_ff;
    nxt_rlock = rlock_ff;
    nxt_core_start = 1'b0;
    nxt_core_sample = 1'b0;
    nxt_aw_got = aw_got_ff;
    nxt_w_got = w_got_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;

    // Write channel: address and data are latched independently.
    if (s_axi_awvalid_in & s_axi_awready_out)
    begin
      nxt_aw_got = 1'b1;
      nxt_awaddr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in & s_axi_wready_out)
    begin
      nxt_w_got = 1'b1;
      nxt_wdata = s_axi_wdata_in;
      nxt_wstrb = s_axi_wstrb_in;
    end
    if (bvalid_ff & s_axi_bready_in)
      nxt_bvalid = 1'b0;
    if (aw_got_ff & w_got_ff & ~bvalid_ff)
    begin
      nxt_aw_got = 1'b0;
      nxt_w_got = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = `ADCS_RESP_OKAY;
      case (awaddr_ff)
        `ADCS_OFF_CTRL:
        begin
          nxt_en = ctrl_m[`ADCS_CTRL_EN];
          nxt_auto = ctrl_m[`ADCS_CTRL_AUTO];
          nxt_ie = ctrl_m[`ADCS_CTRL_IE];
          nxt_div = ctrl_m[`ADCS_CTRL_DIV_LO +: 3];
          nxt_free = ctrl_m[`ADCS_CTRL_FREE];
          if (wstrb_ff[0] & wdata_ff[`ADCS_CTRL_START])
            nxt_start = 1'b1;
          if (wstrb_ff[0] & wdata_ff[`ADCS_CTRL_DONE])
            nxt_done = 1'b0;
        end
        `ADCS_OFF_SEL:
        begin
          nxt_buf_ch = sel_m[3:0];
          nxt_buf_ref = sel_m[`ADCS_SEL_REF];
        end
        `ADCS_OFF_RES_LO, `ADCS_OFF_RES_HI, `ADCS_OFF_STATUS: ;
        default: nxt_bresp = `ADCS_RESP_SLVERR;
      endcase
    end

    // Read channel: reading the low byte locks the result until the high byte is read.
    if (rvalid_ff & s_axi_rready_in)
      nxt_rvalid = 1'b0;
    if (s_axi_arvalid_in & s_axi_arready_out)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp = `ADCS_RESP_OKAY;
      nxt_rdata = '0;
      case (s_axi_araddr_in)
        `ADCS_OFF_CTRL: nxt_rdata = ctrl_word;
        `ADCS_OFF_SEL: nxt_rdata = sel_word;
        `ADCS_OFF_RES_LO:
        begin
          nxt_rdata[7:0] = result_ff[7:0];
          nxt_rlock = 1'b1;
        end
        `ADCS_OFF_RES_HI:
        begin
          nxt_rdata[1:0] = result_ff[9:8];
          nxt_rlock = 1'b0;
        end
        `ADCS_OFF_STATUS: nxt_rdata = stat_word;
        default: nxt_rresp = `ADCS_RESP_SLVERR;
      endcase
    end

    // Entering sleep in an idle single-conversion setup with the interrupt enabled launches a conversion.
    if (sleep_halt_in & ~sleep_d_ff & en_ff & ~auto_ff & ie_ff
        & (state_ff == adcs_pkg::st_idle))
      nxt_start = 1'b1;

    // Conversion sequencing.
    case (state_ff)
      adcs_pkg::st_idle:
      begin
        if (en_ff & auto_ff & ~free_ff & trig_edge)
        begin
          nxt_presc = '0;
          nxt_state = adcs_pkg::st_conv;
          nxt_hc = '0;
          nxt_core_start = 1'b1;
          nxt_first = 1'b0;
          nxt_last_ref = act_ref_ff;
          nxt_samp = `ADCS_SAMP_AUTO;
          nxt_end = `ADCS_END_AUTO;
          if (first_ff | (act_ref_ff != last_ref_ff))
          begin
            nxt_samp = `ADCS_SAMP_FIRST;
            nxt_end = `ADCS_END_FIRST;
          end
        end
        else if (en_ff & start_ff)
          nxt_state = adcs_pkg::st_arm;
      end
      adcs_pkg::st_arm:
      begin
        if (full_tick)
        begin
          nxt_state = adcs_pkg::st_conv;
          nxt_hc = '0;
          nxt_core_start = 1'b1;
          nxt_first = 1'b0;
          nxt_last_ref = act_ref_ff;
          nxt_samp = `ADCS_SAMP_NORM;
          nxt_end = `ADCS_END_NORM;
          if (first_ff | (act_ref_ff != last_ref_ff))
          begin
            nxt_samp = `ADCS_SAMP_FIRST;
            nxt_end = `ADCS_END_FIRST;
          end
        end
      end
      adcs_pkg::st_conv:
      begin
        if (half_tick)
        begin
          nxt_hc = hc_inc;
          if (hc_inc == samp_ff)
            nxt_core_sample = 1'b1;
          if (hc_inc == end_ff)
          begin
            nxt_done = 1'b1;
            if (~rlock_ff)
              nxt_result = core_rsp_in.over ? `ADCS_FULL_SCALE : core_rsp_in.code;
            if (auto_ff & free_ff & start_ff)
            begin
              // The new conversion locks the selection already copied.
              nxt_hc = '0;
              nxt_core_start = 1'b1;
              nxt_last_ref = act_ref_ff;
              nxt_samp = `ADCS_SAMP_FREE;
              nxt_end = `ADCS_END_FREE;
            end
            else
            begin
              nxt_start = 1'b0;
              nxt_state = adcs_pkg::st_idle;
            end
          end
        end
      end
      default: nxt_state = adcs_pkg::st_idle;
    endcase

    // Selection follows the buffer while enabled, except while a conversion holds it.
    if (en_ff & ((state_ff != adcs_pkg::st_conv) || (hc_ff >= end_ff - 6'd2)))
    begin
      nxt_act_ch = buf_ch_ff;
      nxt_act_ref = buf_ref_ff;
    end

    // Disabling aborts any conversion and holds the prescaler at zero.
    if (~en_ff)
    begin
      nxt_presc = '0;
      nxt_state = adcs_pkg::st_idle;
      nxt_start = 1'b0;
      nxt_first = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
    begin
      {en_ff, start_ff, auto_ff, done_ff, ie_ff, free_ff} <= '0;
      div_ff <= '0;
      {buf_ch_ff, act_ch_ff} <= '0;
      {buf_ref_ff, act_ref_ff, last_ref_ff} <= '0;
      first_ff <= 1'b1;
      state_ff <= adcs_pkg::st_idle;
      presc_ff <= '0;
      {hc_ff, samp_ff, end_ff} <= '0;
      result_ff <= '0;
      {rlock_ff, sleep_d_ff, core_start_ff, core_sample_ff} <= '0;
      {trig_s1_ff, trig_s2_ff, trig_s3_ff} <= '0;
      {aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff} <= '0;
      awaddr_ff <= '0;
      {wdata_ff, rdata_ff} <= '0;
      wstrb_ff <= '0;
      {bresp_ff, rresp_ff} <= '0;
    end
    else if (ce_in)
    begin
      {en_ff, start_ff, auto_ff, done_ff, ie_ff, free_ff} <=
        {nxt_en, nxt_start, nxt_auto, nxt_done, nxt_ie, nxt_free};
      div_ff <= nxt_div;
      {buf_ch_ff, act_ch_ff} <= {nxt_buf_ch, nxt_act_ch};
      {buf_ref_ff, act_ref_ff, last_ref_ff} <= {nxt_buf_ref, nxt_act_ref, nxt_last_ref};
      first_ff <= nxt_first;
      state_ff <= nxt_state;
      presc_ff <= nxt_presc;
      {hc_ff, samp_ff, end_ff} <= {nxt_hc, nxt_samp, nxt_end};
      result_ff <= nxt_result;
      {rlock_ff, sleep_d_ff} <= {nxt_rlock, sleep_halt_in};
      {core_start_ff, core_sample_ff} <= {nxt_core_start, nxt_core_sample};
      {trig_s1_ff, trig_s2_ff, trig_s3_ff} <= {trig_in, trig_s1_ff, trig_s2_ff};
      {aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff} <=
        {nxt_aw_got, nxt_w_got, nxt_bvalid, nxt_rvalid};
      awaddr_ff <= nxt_awaddr;
      {wdata_ff, rdata_ff} <= {nxt_wdata, nxt_rdata};
      wstrb_ff <= nxt_wstrb;
      {bresp_ff, rresp_ff} <= {nxt_bresp, nxt_rresp};
    end
  end

endmodule

// ==== tb/adcs_core_model.sv ====
`timescale 1ns/10ps
// The code depends on the locked selection at the sample strobe, so a selection
// that leaks through during a conversion shows up in the result.
module adcs_core_model (
  input wire logic clk_in, // System clock.
  input wire adcs_pkg::adcs_core_req_t req_in, // Strobes and locked selection.
  output adcs_pkg::adcs_core_rsp_t rsp_out // Held result.
);
  initial rsp_out = '0;
  always @(posedge clk_in)
  begin
    if (req_in.sample)
    begin
      rsp_out.code <= {req_in.ref_sel, req_in.channel, 5'h15};
      rsp_out.over <= (req_in.channel == 4'hb);
    end
  end
endmodule

// ==== tb/adcs_chk.sv ====
`timescale 1ns/10ps
module adcs_chk (
  input wire logic ref_clk_in, // Clock.
  input wire logic nrst_in, // Reset.
  input wire logic ce_in, // Enable.
  input wire logic s_axi_awvalid_in, // Bus.
  input wire logic s_axi_awready_out, // Bus.
  input wire logic s_axi_wvalid_in, // Bus.
  input wire logic s_axi_wready_out, // Bus.
  input wire logic [1:0] s_axi_bresp_out, // Bus.
  input wire logic s_axi_bvalid_out, // Bus.
  input wire logic s_axi_bready_in, // Bus.
  input wire logic s_axi_arvalid_in, // Bus.
  input wire logic s_axi_arready_out, // Bus.
  input wire logic [31:0] s_axi_rdata_out, // Bus.
  input wire logic s_axi_rvalid_out, // Bus.
  input wire logic s_axi_rready_in, // Bus.
  input wire adcs_pkg::adcs_core_req_t core_req_out // Core request.
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  a_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data dropped");
  a_ready_blocked: assert property (s_axi_bvalid_out || s_axi_rvalid_out || !ce_in |->
    !(s_axi_bvalid_out || !ce_in) || !s_axi_awready_out && !s_axi_wready_out)
    else $error("write accepted while blocked");
  a_ar_blocked: assert property (s_axi_rvalid_out || !ce_in |-> !s_axi_arready_out)
    else $error("read accepted while blocked");
  a_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
    && s_axi_wready_out |-> ##[1:2] s_axi_bvalid_out) else $error("write not answered");
  a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read not answered");
  a_start_pulse: assert property ($rose(core_req_out.start) |=> !core_req_out.start)
    else $error("start strobe too long");
  a_sample_follows: assert property (core_req_out.start |-> ##[2:60] core_req_out.sample)
    else $error("no sample after start");
  a_sample_pulse: assert property (core_req_out.sample |=> !core_req_out.sample)
    else $error("sample strobe too long");
  a_sel_locked: assert property (core_req_out.start |=>
    ($stable(core_req_out.channel) && $stable(core_req_out.ref_sel)) [*2])
    else $error("selection moved during conversion");
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/10ps
module tb;
  typedef struct {
    logic [7:0] wa;
    logic [31:0] wd;
    logic [1:0] eb;
    logic [7:0] ra;
    logic [31:0] ed;
    logic [1:0] er;
  } adcs_row_t;
  logic ref_clk_in, nrst_in, ce_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
  logic s_axi_arvalid_in, s_axi_rready_in, trig_in, sleep_halt_in, irq_out;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic s_axi_rvalid_out;
  logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out, d;
  logic [3:0] s_axi_wstrb_in;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, r;
  adcs_pkg::adcs_core_rsp_t core_rsp_in;
  adcs_pkg::adcs_core_req_t core_req_out;
  int err_total = 0;
  int samples_checked = 0;
  int starts = 0;
  int n, k, ts1, td1, ts2, td2, ts3, td3;
  adcs_row_t rows [4] = '{'{8'h04, 32'h45, 2'b00, 8'h00, 32'h0, 2'b00},
    '{8'h00, 32'h01, 2'b00, 8'h10, 32'h245, 2'b00},
    '{8'h14, 32'h01, 2'b10, 8'h14, 32'h0, 2'b10},
    '{8'h04, 32'h45, 2'b00, 8'h04, 32'h45, 2'b00}};

  adcs_sequencer dut (.ref_clk_in, .nrst_in, .ce_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
    .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
    .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in,
    .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in,
    .trig_in, .sleep_halt_in, .core_rsp_in, .core_req_out, .irq_out);
  adcs_core_model core (.clk_in(ref_clk_in), .req_in(core_req_out), .rsp_out(core_rsp_in));

  initial
  begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end
  // Counted at the falling edge, where the registered strobe has settled.
  always @(negedge ref_clk_in)
    if (core_req_out.start === 1'b1) starts <= starts + 1;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    if (err_total == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic give_up;
    err_total++;
    $display("mismatch at %0t: wait timed out", $time);
    finish_test;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Handshakes are judged at the falling edge, before the rising edge that completes them,
  // because the readies drop combinationally in the same step as the accepting edge.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int i;
    logic aw_hs, w_hs, b_hs;
    @(posedge ref_clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= v;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    b_hs = 1'b0;
    rs = 2'h3;
    for (i = 0; i < 50 && !b_hs; i++)
    begin
      @(negedge ref_clk_in);
      aw_hs = s_axi_awvalid_in & s_axi_awready_out;
      w_hs = s_axi_wvalid_in & s_axi_wready_out;
      b_hs = (s_axi_bvalid_out === 1'b1);
      rs = s_axi_bresp_out;
      @(posedge ref_clk_in);
      if (aw_hs) s_axi_awvalid_in <= 1'b0;
      if (w_hs) s_axi_wvalid_in <= 1'b0;
    end
    if (!b_hs) give_up;
    s_axi_bready_in <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int i;
    logic ar_hs, r_hs;
    @(posedge ref_clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    r_hs = 1'b0;
    v = '0;
    rs = 2'h3;
    for (i = 0; i < 50 && !r_hs; i++)
    begin
      @(negedge ref_clk_in);
      ar_hs = s_axi_arvalid_in & s_axi_arready_out;
      r_hs = (s_axi_rvalid_out === 1'b1);
      v = s_axi_rdata_out;
      rs = s_axi_rresp_out;
      @(posedge ref_clk_in);
      if (ar_hs) s_axi_arvalid_in <= 1'b0;
    end
    if (!r_hs) give_up;
    s_axi_rready_in <= 1'b0;
  endtask
  // Counts edges up to and including the one that sees the strobe, so gaps subtract cleanly.
  task automatic wait_for(input int w, output int c);
    for (c = 1; c <= 400; c++)
    begin
      @(negedge ref_clk_in);
      if ((w == 0 && core_req_out.start === 1'b1) || (w == 1 && core_req_out.sample === 1'b1)
          || (w == 2 && irq_out === 1'b1)) return;
    end
    give_up;
  endtask
  task automatic conv(input logic [31:0] c, output int ts, output int td);
    axi_wr(8'h00, c, r);
    wait_for(0, n);
    wait_for(1, ts);
    wait_for(2, td);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {nrst_in, s_axi_awaddr_in, s_axi_awvalid_in, s_axi_wdata_in, s_axi_wvalid_in,
      s_axi_bready_in, s_axi_araddr_in, s_axi_arvalid_in, s_axi_rready_in, trig_in,
      sleep_halt_in} = '0;
    ce_in = 1'b1;
    s_axi_wstrb_in = 4'hf;
    repeat (3) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    foreach (rows[i])
    begin
      axi_wr(rows[i].wa, rows[i].wd, r);
      check(32'(r), 32'(rows[i].eb));
      axi_rd(rows[i].ra, d, r);
      check(d, rows[i].ed);
      check(32'(r), 32'(rows[i].er));
    end
    conv(32'h13, ts1, td1);
    axi_rd(8'h00, d, r);
    check(d, 32'h19);
    check(32'(irq_out), 32'h1);
    axi_rd(8'h08, d, r);
    check(d, 32'hb5);
    axi_rd(8'h0c, d, r);
    check(d, 32'h2);
    conv(32'h1b, ts2, td2);
    check(32'(ts1 - ts2), 32'd24);
    check(32'(ts1 + td1 - ts2 - td2), 32'd24);
    axi_wr(8'h04, 32'h0b, r);
    conv(32'h1b, ts3, td3);
    check(32'(ts3 - ts2), 32'd24);
    axi_rd(8'h08, d, r);
    check(d, 32'hff);
    axi_wr(8'h04, 32'h05, r);
    conv(32'h1b, ts3, td3);
    axi_rd(8'h0c, d, r);
    check(d, 32'h3);
    axi_wr(8'h04, 32'h06, r);
    axi_wr(8'h00, 32'h1d, r);
    k = starts;
    trig_in <= 1'b1;
    wait_for(1, n);
    check(32'(n >= 4 && n <= 10), 32'h1);
    axi_wr(8'h04, 32'h07, r);
    trig_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    trig_in <= 1'b1;
    wait_for(2, n);
    check(32'(starts - k), 32'h1);
    axi_rd(8'h08, d, r);
    check(d, 32'hd5);
    axi_rd(8'h10, d, r);
    check(d, 32'h07);
    axi_rd(8'h0c, d, r);
    trig_in <= 1'b0;
    ce_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    ce_in <= 1'b1;
    axi_wr(8'h00, 32'h19, r);
    sleep_halt_in <= 1'b1;
    wait_for(0, n);
    check(32'(n < 10), 32'h1);
    wait_for(2, n);
    check(32'(irq_out), 32'h1);
    @(posedge ref_clk_in);
    sleep_halt_in <= 1'b0;
    axi_wr(8'h00, 32'h11f, r);
    wait_for(1, n);
    wait_for(1, n);
    check(32'(n), 32'd28);
    axi_wr(8'h00, 32'h0, r);
    finish_test;
  end
endmodule

bind adcs_sequencer adcs_chk chk (.ref_clk_in, .nrst_in, .ce_in, .s_axi_awvalid_in,
  .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out,
  .s_axi_bready_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rvalid_out,
  .s_axi_rready_in, .core_req_out);
